/* File: hw/edge_irq_defs.svh */
`ifndef EDGE_IRQ_DEFS_SVH
`define EDGE_IRQ_DEFS_SVH

// timing: one ticker step per microsecond at the 40 MHz clock
`define CLK_PERIOD_NS       25
`define TICK_PERIOD_NS      1000
`define TICK_CYCLES         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

// record numbers for the diagnostic record
`define REC_DIAG_SHORT      8'h00
`define REC_DIAG_FULL       8'h01

// object indices
`define IDX_DIAG_SHORT      16'h2f00
`define IDX_DIAG_FULL       16'h2f01
`define IDX_PROC_REC        16'h5000
`define IDX_DIAG_REC        16'h5005
`define IDX_DIAG_EN         16'h3100
`define IDX_RISE_EN         16'h3103
`define IDX_FALL_EN         16'h3104

// process interrupt record offsets (subindex under the record index)
`define OFS_EDGE_CAUSE      8'h02
`define OFS_INPUT_SNAPSHOT  8'h03
`define OFS_TS_HIGH         8'h04
`define OFS_TS_LOW          8'h05

// diagnostic record subindex of byte 0
`define OFS_DIAG_FIRST      8'h02

// diagnostic enable byte values
`define DIAG_EN_ON          8'h40
`define DIAG_EN_OFF         8'h00

// diagnostic status bit positions
`define ERRA_FAILURE_BIT    0
`define ERRA_CHANNEL_BIT    3
`define ERRD_OVERFLOW_BIT   3
`define ERRD_LOST_BIT       6

// diagnostic record layout
`define DIAG_SHORT_LEN      8'd4
`define DIAG_FULL_LEN       8'd20
`define DIAG_POS_MODTYP     8'd1
`define DIAG_POS_ERRD       8'd3
`define DIAG_POS_CHTYP      8'd4
`define DIAG_POS_NUMCH      8'd6
`define DIAG_POS_CHERR      8'd7
`define DIAG_POS_US         8'd16
`define DIAG_VAL_MODTYP     8'h1f
`define DIAG_VAL_CHTYP      8'h70
`define DIAG_VAL_NUMCH      8'h02

// reset values
`define RST_BYTE            8'h00
`define RST_TS              16'h0000
`define RST_TICK            32'h0000_0000

`endif

/* File: hw/edge_irq_pkg.sv */
package edge_irq_pkg;

  // addressing space of a record read
  typedef enum logic [2:0] {
    SPACE_REC = 3'b001,  // record number
    SPACE_IDX = 3'b010,  // object index, byte offset
    SPACE_SUB = 3'b100   // object index plus subindex
  } rd_space_t;

  // one record read request
  typedef struct packed {
    rd_space_t   space;
    logic [15:0] sel;    // record number in low byte, or object index
    logic [7:0]  pos;    // byte offset, or subindex
  } rd_req_t;

  // process interrupt record
  typedef struct packed {
    logic [7:0]  cause;
    logic [7:0]  snap;
    logic [15:0] ts;
  } proc_rec_t;

  // diagnostic interrupt life cycle
  typedef enum logic [1:0] {
    DIAG_IDLE   = 2'b01,
    DIAG_ACTIVE = 2'b10
  } diag_state_t;

endpackage

/* File: hw/input_edge_interrupt_diag.sv */
// Overview of operation
// R01: enabled channel edge raises interrupt, sets cause bit
// R02: snapshot both input levels at interrupt
// R03: 32-bit microsecond counter from zero at reset
// R04: counter wraps to zero after maximum
// R05: record carries counter low 16 bits
// R06: diag interrupt enable; overflow, lost sources
// R07: incoming diag interrupt when condition arises
// R08: going diag interrupt when cause clears
// R09: channel events discarded while diag active
// R10: fault indicator on incoming through going
// R11: full diag record 01h, short 00h
// R12: object index 2F01h full, 2F00h short
// R13: process record 5000h, diag 5005h
// R14: emergency message or diagnostics message delivery
// R15: per-channel rise and fall enable bits
// R16: diag enable byte 00h off, 40h on
// R17: overflow bit 3, lost bit 6
// R18: edge while record undelivered is lost
`timescale 1ns/1ps
`default_nettype none
`include "edge_irq_defs.svh"

module input_edge_interrupt_diag
  import edge_irq_pkg::*;
#(
  parameter int TICK_CYC = `TICK_CYCLES  // clock cycles per microsecond
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [1:0]  input_channel,          // filtered input levels
  input  wire logic        buf_overflow,           // diagnostic buffer overflow level
  input  wire logic        fieldbus_is_canopen,    // selects message kind
  input  wire logic        prm_wr,                 // parameter write strobe
  input  wire logic [15:0] prm_index,              // parameter object index
  input  wire logic [7:0]  prm_data,               // parameter byte
  input  wire logic        proc_ack,               // master took the process record
  input  wire logic        rd_req,                 // record read strobe
  input  wire rd_req_t     rd_cmd,                 // record read address
  output logic             emcy_req,               // record waits, emergency path
  output logic             diag_msg_req,           // record waits, diagnostics path
  output logic             diag_incoming,          // one-cycle incoming pulse
  output logic             diag_going,             // one-cycle going pulse
  output logic             module_fault_indicator, // fault lamp
  output logic             rd_ack,                 // read answer pulse
  output logic [7:0]       rd_data,                // read answer byte
  output logic             rd_err                  // unmapped read
);

  logic [31:0] tick;              // microsecond count
  logic [1:0]  prev_ff;           // input levels one cycle back
  logic [1:0]  rise_irq_enable;   // rising edge enables
  logic [1:0]  fall_irq_enable;   // falling edge enables
  logic        diag_en_ff;        // diagnostic interrupt enable
  logic [1:0]  edge_vec;          // enabled edges this cycle
  logic        edge_any;          // any enabled edge
  logic        pend_ff;           // record not yet delivered
  proc_rec_t   rec_ff;            // process interrupt record
  logic        accept;            // edge stored as new record
  logic        lost_ev;           // edge dropped for an old record
  logic        lost_ff;           // process interrupt lost flag
  logic [1:0]  cherr_ff;          // per-channel edge lost
  logic        diag_cause;        // any diagnostic source present
  diag_state_t st_ff;             // diag life cycle
  diag_state_t nxt_st;
  logic        active;            // inside incoming/going window
  logic [31:0] diag_us_ff;        // ticker at incoming
  logic        emcy_ff, dmsg_ff, din_ff, dgo_ff, led_ff;
  logic        ack_ff, err_ff;
  logic [7:0]  data_ff;
  logic [7:0]  nxt_data;
  logic        nxt_err;
  logic [7:0]  errd;              // internal diagnostic status byte

  us_ticker #(.TICK_CYC(TICK_CYC)) u_ticker (
    .clk      (clk),
    .rst      (rst),
    .count_ff (tick)
  );

  // parameter writes; diag enable values other than 00h and 40h are not permissible, so kept out; rise and fall enables take bits 1:0 of any byte
  always_ff @(posedge clk) begin
    if (rst) begin
      rise_irq_enable <= 2'b00;
      fall_irq_enable <= 2'b00;
      diag_en_ff      <= 1'b0;
    end else if (prm_wr) begin
      if (prm_index == `IDX_RISE_EN) begin
        rise_irq_enable <= prm_data[1:0];                    // R15
      end
      if (prm_index == `IDX_FALL_EN) begin
        fall_irq_enable <= prm_data[1:0];                    // R15
      end
      if (prm_index == `IDX_DIAG_EN && prm_data == `DIAG_EN_ON) begin
        diag_en_ff <= 1'b1;                                  // R16 R06
      end
      if (prm_index == `IDX_DIAG_EN && prm_data == `DIAG_EN_OFF) begin
        diag_en_ff <= 1'b0;                                  // R16
      end
    end
  end

  // edge detection against last cycle's level
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_ff <= 2'b00;
    end else begin
      prev_ff <= input_channel;
    end
  end

  assign edge_vec = (input_channel & ~prev_ff & rise_irq_enable)
                  | (~input_channel & prev_ff & fall_irq_enable);  // R15
  assign edge_any = |edge_vec;
  assign active   = (st_ff == DIAG_ACTIVE);
  // an ack in the same cycle frees the slot, so the new edge is kept
  assign accept   = edge_any && !active && !(pend_ff && !proc_ack);   // R09
  assign lost_ev  = edge_any && !active && pend_ff && !proc_ack;      // R18

  // pending record; a new edge wins over the ack of the old one
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff <= 1'b0;
    end else if (accept) begin
      pend_ff <= 1'b1;                                       // R01
    end else if (proc_ack) begin
      pend_ff <= 1'b0;
    end
  end

  // record capture: cause, levels and low half of ticker together
  always_ff @(posedge clk) begin
    if (rst) begin
      rec_ff <= '{cause: `RST_BYTE, snap: `RST_BYTE, ts: `RST_TS};
    end else if (accept) begin
      rec_ff.cause <= {6'b000000, edge_vec};                 // R01
      rec_ff.snap  <= {6'b000000, input_channel};            // R02
      rec_ff.ts    <= tick[15:0];                            // R05
    end
  end

  // message kind follows the fieldbus; level while the record waits
  always_ff @(posedge clk) begin
    if (rst) begin
      emcy_ff <= 1'b0;
      dmsg_ff <= 1'b0;
    end else begin
      emcy_ff <= (accept || (pend_ff && !proc_ack)) && fieldbus_is_canopen;   // R14
      dmsg_ff <= (accept || (pend_ff && !proc_ack)) && !fieldbus_is_canopen;  // R14
    end
  end

  // lost flag lasts until the stalled record is taken; set beats clear
  always_ff @(posedge clk) begin
    if (rst) begin
      lost_ff  <= 1'b0;
      cherr_ff <= 2'b00;
    end else if (lost_ev) begin
      lost_ff  <= 1'b1;                                      // R18
      cherr_ff <= cherr_ff | edge_vec;
    end else if (proc_ack) begin
      lost_ff  <= 1'b0;
      cherr_ff <= 2'b00;
    end
  end

  // neither source can be masked on its own
  assign diag_cause = buf_overflow | lost_ff;                // R06
  assign errd = {1'b0, lost_ff, 2'b00, buf_overflow, 3'b000};  // R17

  // diag life cycle
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      DIAG_IDLE: begin
        if (diag_cause && diag_en_ff) begin
          nxt_st = DIAG_ACTIVE;                              // R07
        end
      end
      DIAG_ACTIVE: begin
        if (!diag_cause) begin
          nxt_st = DIAG_IDLE;                                // R08
        end
      end
      default: nxt_st = DIAG_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= DIAG_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pulses and lamp; lamp spans exactly the active window
  always_ff @(posedge clk) begin
    if (rst) begin
      din_ff <= 1'b0;
      dgo_ff <= 1'b0;
      led_ff <= 1'b0;
    end else begin
      din_ff <= (st_ff == DIAG_IDLE) && (nxt_st == DIAG_ACTIVE);  // R07
      dgo_ff <= active && (nxt_st == DIAG_IDLE);                  // R08
      led_ff <= (nxt_st == DIAG_ACTIVE);                          // R10
    end
  end

  // ticker value at the moment of the incoming diagnostic
  always_ff @(posedge clk) begin
    if (rst) begin
      diag_us_ff <= `RST_TICK;
    end else if ((st_ff == DIAG_IDLE) && (nxt_st == DIAG_ACTIVE)) begin
      diag_us_ff <= tick;                                    // R07
    end
  end

  // one byte of the diagnostic record; used by every access space
  function automatic logic [7:0] diag_byte(input logic [7:0]  pos,
                                           input logic [7:0]  err_d,
                                           input logic [1:0]  chan_err,
                                           input logic        act,
                                           input logic [31:0] us);
    logic [7:0] b;
    b = `RST_BYTE;
    if (pos == 8'd0) begin
      b[`ERRA_FAILURE_BIT] = act;
      b[`ERRA_CHANNEL_BIT] = |chan_err;
    end else if (pos == `DIAG_POS_MODTYP) begin
      b = `DIAG_VAL_MODTYP;
    end else if (pos == `DIAG_POS_ERRD) begin
      b = err_d;
    end else if (pos == `DIAG_POS_CHTYP) begin
      b = `DIAG_VAL_CHTYP;
    end else if (pos == `DIAG_POS_NUMCH) begin
      b = `DIAG_VAL_NUMCH;
    end else if (pos == `DIAG_POS_CHERR) begin
      b = {6'b000000, chan_err};
    end else if (pos >= `DIAG_POS_US && pos < `DIAG_FULL_LEN) begin
      b = us[8'(pos - `DIAG_POS_US) * 8 +: 8];
    end
    return b;
  endfunction

  // read decode; anything unmapped answers with the error flag
  always_comb begin
    nxt_data = `RST_BYTE;
    nxt_err  = 1'b1;
    unique case (rd_cmd.space)
      SPACE_REC: begin
        if (rd_cmd.sel[7:0] == `REC_DIAG_FULL && rd_cmd.pos < `DIAG_FULL_LEN) begin
          nxt_data = diag_byte(rd_cmd.pos, errd, cherr_ff, active, diag_us_ff);  // R11
          nxt_err  = 1'b0;
        end else if (rd_cmd.sel[7:0] == `REC_DIAG_SHORT && rd_cmd.pos < `DIAG_SHORT_LEN) begin
          nxt_data = diag_byte(rd_cmd.pos, errd, cherr_ff, active, diag_us_ff);  // R11
          nxt_err  = 1'b0;
        end
      end
      SPACE_IDX: begin
        if (rd_cmd.sel == `IDX_DIAG_FULL && rd_cmd.pos < `DIAG_FULL_LEN) begin
          nxt_data = diag_byte(rd_cmd.pos, errd, cherr_ff, active, diag_us_ff);  // R12
          nxt_err  = 1'b0;
        end else if (rd_cmd.sel == `IDX_DIAG_SHORT && rd_cmd.pos < `DIAG_SHORT_LEN) begin
          nxt_data = diag_byte(rd_cmd.pos, errd, cherr_ff, active, diag_us_ff);  // R12
          nxt_err  = 1'b0;
        end
      end
      SPACE_SUB: begin
        if (rd_cmd.sel == `IDX_PROC_REC) begin
          nxt_err = 1'b0;
          if (rd_cmd.pos == `OFS_EDGE_CAUSE) begin
            nxt_data = rec_ff.cause;                         // R13
          end else if (rd_cmd.pos == `OFS_INPUT_SNAPSHOT) begin
            nxt_data = rec_ff.snap;
          end else if (rd_cmd.pos == `OFS_TS_HIGH) begin
            nxt_data = rec_ff.ts[15:8];
          end else if (rd_cmd.pos == `OFS_TS_LOW) begin
            nxt_data = rec_ff.ts[7:0];
          end else begin
            nxt_err = 1'b1;
          end
        end else if (rd_cmd.sel == `IDX_DIAG_REC && rd_cmd.pos >= `OFS_DIAG_FIRST
                     && rd_cmd.pos < `DIAG_FULL_LEN + `OFS_DIAG_FIRST) begin
          nxt_data = diag_byte(rd_cmd.pos - `OFS_DIAG_FIRST, errd, cherr_ff, active,
                               diag_us_ff);                  // R13
          nxt_err  = 1'b0;
        end
      end
      default: nxt_err = 1'b1;
    endcase
  end

  // read answer one cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_ff  <= 1'b0;
      err_ff  <= 1'b0;
      data_ff <= `RST_BYTE;
    end else begin
      ack_ff  <= rd_req;
      err_ff  <= rd_req && nxt_err;
      data_ff <= rd_req ? nxt_data : `RST_BYTE;
    end
  end

  assign emcy_req               = emcy_ff;
  assign diag_msg_req           = dmsg_ff;
  assign diag_incoming          = din_ff;
  assign diag_going             = dgo_ff;
  assign module_fault_indicator = led_ff;
  assign rd_ack                 = ack_ff;
  assign rd_data                = data_ff;
  assign rd_err                 = err_ff;

  property p_cause;
    @(posedge clk) disable iff (rst)
    accept |=> (rec_ff.cause == {6'b000000, $past(edge_vec)}) && pend_ff;
  endproperty
  a_cause: assert property (p_cause) else $error("cause byte wrong"); // R01

  property p_snap;
    @(posedge clk) disable iff (rst)
    accept |=> (rec_ff.snap[1:0] == $past(input_channel)) && (rec_ff.snap[7:2] == 6'h00);
  endproperty
  a_snap: assert property (p_snap) else $error("input snapshot wrong"); // R02

  property p_ts;
    @(posedge clk) disable iff (rst)
    accept |=> (rec_ff.ts == $past(tick[15:0]));
  endproperty
  a_ts: assert property (p_ts) else $error("timestamp wrong"); // R05

  property p_masked;
    @(posedge clk) disable iff (rst)
    (!pend_ff && (input_channel ^ prev_ff) == 2'b00) |=> !pend_ff;
  endproperty
  a_masked: assert property (p_masked) else $error("record without edge"); // R15

  property p_lost;
    @(posedge clk) disable iff (rst)
    (edge_any && !active && pend_ff && !proc_ack) |=> lost_ff ##0 $stable(rec_ff);
  endproperty
  a_lost: assert property (p_lost) else $error("lost edge not flagged"); // R18

  property p_incoming;
    @(posedge clk) disable iff (rst)
    (!active && diag_en_ff && diag_cause) |=> diag_incoming && module_fault_indicator;
  endproperty
  a_incoming: assert property (p_incoming) else $error("no incoming diag"); // R07

  property p_going;
    @(posedge clk) disable iff (rst)
    (active && !diag_cause) |=> diag_going && !module_fault_indicator;
  endproperty
  a_going: assert property (p_going) else $error("no going diag"); // R08

  property p_discard;
    @(posedge clk) disable iff (rst)
    (active && edge_any) |=> $stable(rec_ff);
  endproperty
  a_discard: assert property (p_discard) else $error("event stored in diag window"); // R09

  property p_led_rise;
    @(posedge clk) disable iff (rst)
    $rose(module_fault_indicator) |-> diag_incoming;
  endproperty
  a_led_rise: assert property (p_led_rise) else $error("lamp on without incoming"); // R10

  property p_short_rec;
    @(posedge clk) disable iff (rst)
    (rd_req && rd_cmd.space == SPACE_REC && rd_cmd.sel[7:0] == `REC_DIAG_SHORT
     && rd_cmd.pos >= `DIAG_SHORT_LEN) |=> rd_ack && rd_err;
  endproperty
  a_short_rec: assert property (p_short_rec) else $error("short record too long"); // R11

  property p_diag_en;
    @(posedge clk) disable iff (rst)
    (prm_wr && prm_index == `IDX_DIAG_EN && prm_data == `DIAG_EN_ON) |=> diag_en_ff;
  endproperty
  a_diag_en: assert property (p_diag_en) else $error("diag enable not taken"); // R16

endmodule
`default_nettype wire

/* File: hw/us_ticker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "edge_irq_defs.svh"

module us_ticker #(
  parameter int TICK_CYC = `TICK_CYCLES  // clock cycles per microsecond
) (
  input  wire logic        clk,
  input  wire logic        rst,
  output logic [31:0]      count_ff     // free running microsecond count
);

  logic [7:0] pre_ff;                   // cycle prescaler
  logic       step;                     // last cycle of a microsecond

  assign step = (pre_ff == 8'(TICK_CYC - 1));

  // prescaler: wraps every microsecond
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_ff <= 8'h00;
    end else if (step) begin
      pre_ff <= 8'h00;
    end else begin
      pre_ff <= pre_ff + 8'h01;
    end
  end

  // counter starts at zero and wraps to zero past its top
  always_ff @(posedge clk) begin
    if (rst) begin
      count_ff <= `RST_TICK;              // R03
    end else if (step) begin
      count_ff <= count_ff + 32'h0000_0001;  // R03 R04
    end
  end

  property p_tick_step;
    @(posedge clk) disable iff (rst)
    step |=> (count_ff == $past(count_ff) + 32'h0000_0001);
  endproperty
  a_tick_step: assert property (p_tick_step) else $error("ticker missed its step"); // R03

  property p_tick_wrap;
    @(posedge clk) disable iff (rst)
    (step && count_ff == 32'hffff_ffff) |=> (count_ff == 32'h0000_0000);
  endproperty
  a_tick_wrap: assert property (p_tick_wrap) else $error("ticker did not wrap"); // R04

endmodule
`default_nettype wire

/* File: tb/input_edge_interrupt_diag_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "edge_irq_defs.svh"

module input_edge_interrupt_diag_test;
  import edge_irq_pkg::*;

  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [1:0] inch = 2'h0;      // input levels
  logic       ovf = 1'b0;       // buffer overflow level
  logic       canopen = 1'b1;   // message path select
  logic       prm_wr = 1'b0;
  logic [15:0] prm_index = 16'h0000;
  logic [7:0] prm_data = 8'h00;
  logic       proc_ack;
  logic       hold = 1'b1;      // master stalls at start
  logic       rd_req = 1'b0;
  rd_req_t    rd_cmd = '0;
  logic       emcy_req, diag_msg_req, diag_incoming, diag_going;
  logic       lamp, rd_ack, rd_err;
  logic [7:0] rd_data;
  logic [8:0] exp_q[$];         // expected {err, byte} per read
  logic [8:0] e;
  int         n_fail = 0;
  int         n_compared = 0;

  always #12.5 clk = ~clk;

  // short tick so the ticker moves during the run
  input_edge_interrupt_diag #(.TICK_CYC(2)) dut_u (
    .clk(clk), .rst(rst), .input_channel(inch), .buf_overflow(ovf),
    .fieldbus_is_canopen(canopen), .prm_wr(prm_wr), .prm_index(prm_index),
    .prm_data(prm_data), .proc_ack(proc_ack), .rd_req(rd_req), .rd_cmd(rd_cmd),
    .emcy_req(emcy_req), .diag_msg_req(diag_msg_req),
    .diag_incoming(diag_incoming), .diag_going(diag_going),
    .module_fault_indicator(lamp), .rd_ack(rd_ack), .rd_data(rd_data),
    .rd_err(rd_err));

  master_model master_u (
    .clk(clk), .rst(rst), .emcy_req(emcy_req), .diag_msg_req(diag_msg_req),
    .hold(hold), .proc_ack(proc_ack));

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // parameter byte write, one strobe cycle
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge clk);
    prm_wr <= 1'b1;
    prm_index <= idx;
    prm_data <= d;
    @(posedge clk);
    prm_wr <= 1'b0;
  endtask

  // record read; the note goes on the queue before the request
  task automatic rd(input rd_space_t s, input logic [15:0] sel,
                    input logic [7:0] pos, input logic [8:0] exp);
    exp_q.push_back(exp);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_cmd <= '{space: s, sel: sel, pos: pos};
    @(posedge clk);
    rd_req <= 1'b0;
  endtask

  // bounded wait for a design output; a timeout ends the run
  task automatic wait_hi(input int which);
    logic s;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      case (which)
        0: s = diag_incoming;
        1: s = diag_going;
        2: s = emcy_req;
        default: s = diag_msg_req;
      endcase
      if (s === 1'b1) return;
    end
    n_fail++;
    $display("mismatch t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    give_verdict();
  endtask

  task automatic edge_to(input logic [1:0] v);
    repeat ($urandom_range(1, 5)) @(posedge clk);
    inch <= v;
  endtask

  // watcher: each answer takes the oldest note
  always @(negedge clk) begin
    if (rd_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("mismatch t=%0t got=%h exp=%h", $time, rd_data, 8'h00);
      end else begin
        e = exp_q.pop_front();
        chk({rd_err, rd_data}, e);
      end
    end
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(8));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk({8'h0, lamp}, 9'h0);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_EDGE_CAUSE, 9'h000);
    wr(`IDX_RISE_EN, 8'hff);
    wr(`IDX_FALL_EN, 8'h01);
    // channel 0 rise on the emergency path, master stalls
    edge_to(2'b01);
    wait_hi(2);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_EDGE_CAUSE, 9'h001);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_INPUT_SNAPSHOT, 9'h001);
    hold <= 1'b0;
    repeat (8) @(negedge clk);
    chk({8'h0, emcy_req}, 9'h0);
    // channel 1 rise on the diagnostics path; inputs change on the rising edge
    @(posedge clk);
    hold <= 1'b1;
    canopen <= 1'b0;
    edge_to(2'b11);
    wait_hi(3);
    rd(SPACE_REC, {8'h0, `REC_DIAG_FULL}, 8'd0, 9'h000);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_EDGE_CAUSE, 9'h002);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_INPUT_SNAPSHOT, 9'h003);
    // a bad enable value is ignored, so the lost edge stays quiet
    wr(`IDX_DIAG_EN, 8'h01 + 8'($urandom_range(0, 62)));
    edge_to(2'b10);
    repeat (6) @(negedge clk);
    chk({8'h0, lamp}, 9'h0);
    wr(`IDX_DIAG_EN, `DIAG_EN_ON);
    wait_hi(0);
    @(negedge clk);
    chk({8'h0, lamp}, 9'h001);
    rd(SPACE_REC, {8'h0, `REC_DIAG_FULL}, `DIAG_POS_ERRD, 9'h040);
    rd(SPACE_REC, {8'h0, `REC_DIAG_FULL}, `DIAG_POS_CHERR, 9'h001);
    rd(SPACE_IDX, `IDX_DIAG_SHORT, 8'd0, 9'h009);
    rd(SPACE_IDX, `IDX_DIAG_FULL, `DIAG_POS_CHTYP, 9'h070);
    rd(SPACE_REC, {8'h0, `REC_DIAG_SHORT}, 8'd1, 9'h01f);
    rd(SPACE_REC, {8'h0, `REC_DIAG_SHORT}, 8'd4, 9'h100);
    rd(SPACE_SUB, `IDX_DIAG_REC, 8'h08, 9'h002);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_EDGE_CAUSE, 9'h002);
    rd(SPACE_SUB, 16'h1234, 8'h02, 9'h100);
    // master takes the record: lost clears, going follows by itself
    hold <= 1'b0;
    wait_hi(1);
    @(negedge clk);
    chk({8'h0, lamp}, 9'h0);
    // overflow opens a window in which edges are dropped
    @(posedge clk);
    ovf <= 1'b1;
    wait_hi(0);
    // channel 0 rise is enabled, so only the window can drop it
    edge_to(2'b11);
    repeat (6) @(negedge clk);
    chk({8'h0, emcy_req | diag_msg_req}, 9'h0);
    rd(SPACE_SUB, `IDX_PROC_REC, `OFS_EDGE_CAUSE, 9'h002);
    rd(SPACE_SUB, `IDX_DIAG_REC, 8'h05, 9'h008);
    @(negedge clk);
    chk({8'h0, lamp}, 9'h001);
    @(posedge clk);
    ovf <= 1'b0;
    wait_hi(1);
    @(negedge clk);
    chk({8'h0, lamp}, 9'h0);
    repeat (4) @(posedge clk);
    chk({1'b0, 8'(exp_q.size())}, 9'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: tb/master_model.sv */
`timescale 1ns/1ps
`default_nettype none

// backplane master: takes a waiting process record by a proc_ack pulse
module master_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic emcy_req,     // record waits, emergency path
  input  wire logic diag_msg_req, // record waits, diagnostics path
  input  wire logic hold,         // slow master: leave the record pending
  output logic      proc_ack      // record taken
);
  logic [1:0] wait_ff; // cycles to let the request fall after an ack

  // ack once per record; the gap stops a second ack on a falling request
  // proc_ack is written once per edge, so no double assignment in a time step
  always @(posedge clk) begin
    if (rst) begin
      proc_ack <= 1'b0;
      wait_ff  <= 2'h0;
    end else if (wait_ff != 2'h0) begin
      proc_ack <= 1'b0;
      wait_ff  <= wait_ff - 2'h1;
    end else begin
      proc_ack <= (emcy_req | diag_msg_req) && !hold;
      if ((emcy_req | diag_msg_req) && !hold) begin
        wait_ff <= 2'h3;
      end
    end
  end
endmodule
`default_nettype wire
